// >>> sbc_defs.svh
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// Status word bit positions.
`define SBC_BIT_IO 0
`define SBC_BIT_CD 1
`define SBC_BIT_MSG 2
`define SBC_BIT_SEL 3
`define SBC_BIT_BSY 4
`define SBC_BIT_REQ 5
`define SBC_BIT_ACK 6
`define SBC_BIT_ATN 7
`define SBC_BIT_RST 8
`define SBC_BIT_LPAR 9
`define SBC_BIT_HPAR 10
`define SBC_BIT_LPERR 11
`define SBC_BIT_HPERR 12
`define SBC_BIT_WIDTH 15

// Widths and reset values.
`define SBC_STATUS_W 16
`define SBC_MATCH_W 13
`define SBC_STATUS_RST 16'h0000

// Phase codes on message, control/data, input/output.
`define SBC_PH_DATA_OUT 3'h0
`define SBC_PH_DATA_IN 3'h1
`define SBC_PH_COMMAND 3'h2
`define SBC_PH_STATUS 3'h3
`define SBC_PH_MSG_OUT 3'h6
`define SBC_PH_MSG_IN 3'h7

`endif

// >>> sbc_pkg.sv
package sbc_pkg;
    // One-hot bus condition codes.
    typedef enum logic [13:0] {
        SBC_COND_NONE = 14'h0001,
        SBC_COND_RESET = 14'h0002,
        SBC_COND_BUS_FREE = 14'h0004,
        SBC_COND_ARBITRATION = 14'h0008,
        SBC_COND_ATTENTION_ARBITRATION = 14'h0010,
        SBC_COND_SELECTION = 14'h0020,
        SBC_COND_RESELECTION = 14'h0040,
        SBC_COND_DATA_OUT = 14'h0080,
        SBC_COND_DATA_IN = 14'h0100,
        SBC_COND_COMMAND = 14'h0200,
        SBC_COND_STATUS = 14'h0400,
        SBC_COND_MSG_OUT = 14'h0800,
        SBC_COND_MSG_IN = 14'h1000,
        SBC_COND_UNDEFINED_PHASE = 14'h2000
    } sbc_cond_t;

    // Parity error report.
    typedef enum logic [3:0] {
        SBC_PERR_NONE = 4'h1,
        SBC_PERR_LOW = 4'h2,
        SBC_PERR_HIGH = 4'h4,
        SBC_PERR_BOTH = 4'h8
    } sbc_perr_t;
endpackage

// >>> sbc_classifier.sv
`include "sbc_defs.svh"

// Notes on behaviour
// - Input/output direction sits at status bit 0.
// - Control/data sits at status bit 1.
// - Message line sits at status bit 2.
// - Select at bit 3, busy at 4.
// - Bus reset line sits at status bit 8.
// - Low byte odd parity bit at 9.
// - High byte odd parity bit at 10.
// - Low byte parity failure sets bit 11.
// - High byte parity failure sets bit 12.
// - Bus-width selector reported on bit 15.
module sbc_classifier
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic io_pin,
    input wire logic cd_pin,
    input wire logic msg_pin,
    input wire logic sel_pin,
    input wire logic bsy_pin,
    input wire logic req_pin,
    input wire logic ack_pin,
    input wire logic atn_pin,
    input wire logic rst_pin,
    input wire logic [15:0] data_pin,
    input wire logic low_byte_parity_bit_pin,
    input wire logic high_byte_parity_bit_pin,
    input wire logic bus_width_switch,
    output logic [15:0] status_word,
    output logic bus_width_indicator,
    output sbc_pkg::sbc_cond_t condition,
    output sbc_pkg::sbc_perr_t parity_report,
    output logic sample_valid
);
    import sbc_pkg::*;

    // Every pin shares one two-stage synchroniser; the group is 28 bits wide.
    // One shared vector keeps all lines on the same two edges.
    localparam int PIN_W = 28;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] samp_r;
    logic hs_prev_r;
    logic sample_evt;
    logic s_io, s_cd, s_msg, s_sel, s_bsy, s_req, s_ack, s_atn, s_rst;
    logic [15:0] s_data;
    logic s_lpar, s_hpar, s_width;
    logic lperr, hperr;
    logic [`SBC_MATCH_W-1:0] match_word;
    logic [15:0] status_nxt;
    sbc_cond_t cond_nxt;
    sbc_perr_t perr_nxt;

    assign pins_raw = {bus_width_switch, high_byte_parity_bit_pin, low_byte_parity_bit_pin,
                       data_pin, rst_pin, atn_pin, ack_pin, req_pin, bsy_pin, sel_pin,
                       msg_pin, cd_pin, io_pin};

    // Two flip-flops per pin; only the second stage feeds logic.
    // Bits of a wide bus may settle on different edges; the later sample stage
    // gives them a cycle to agree before a record is taken.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    // The handshake edge is judged between two sampled stages, never against the
    // synchroniser, so data and control in a record have settled with the edge.
    // The previous handshake level is therefore one cycle behind the sample stage.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            samp_r <= '0;
            hs_prev_r <= 1'b0;
        end
        else
        begin
            samp_r <= sync2_r;
            hs_prev_r <= samp_r[`SBC_BIT_REQ] | samp_r[`SBC_BIT_ACK];
        end
    end

    // A new sample when req OR ack changes level, or on any change of busy, select, reset,
    // attention. Direction, phase, data and parity lines alone never trigger one:
    // they ride along with the next bus step, which keeps one record per step.
    assign sample_evt = ((samp_r[`SBC_BIT_REQ] | samp_r[`SBC_BIT_ACK]) != hs_prev_r)
                        || (samp_r[`SBC_BIT_SEL] != status_word[`SBC_BIT_SEL])
                        || (samp_r[`SBC_BIT_BSY] != status_word[`SBC_BIT_BSY])
                        || (samp_r[`SBC_BIT_RST] != status_word[`SBC_BIT_RST])
                        || (samp_r[`SBC_BIT_ATN] != status_word[`SBC_BIT_ATN]);

    assign s_io = samp_r[0];
    assign s_cd = samp_r[1];
    assign s_msg = samp_r[2];
    assign s_sel = samp_r[3];
    assign s_bsy = samp_r[4];
    assign s_req = samp_r[5];
    assign s_ack = samp_r[6];
    assign s_atn = samp_r[7];
    assign s_rst = samp_r[8];
    assign s_data = samp_r[24:9];
    assign s_lpar = samp_r[25];
    assign s_hpar = samp_r[26];
    assign s_width = samp_r[27];

    // Odd parity: byte plus parity bit must hold an odd count of ones.
    // Parity is judged on every record, so an idle bus with stray data may show errors.
    assign lperr = ~(^{s_data[7:0], s_lpar});
    assign hperr = ~(^{s_data[15:8], s_hpar});

    // Pack the status word at fixed positions.
    always_comb
    begin
        status_nxt = `SBC_STATUS_RST;
        status_nxt[`SBC_BIT_IO] = s_io;
        status_nxt[`SBC_BIT_CD] = s_cd;
        status_nxt[`SBC_BIT_MSG] = s_msg;
        status_nxt[`SBC_BIT_SEL] = s_sel;
        status_nxt[`SBC_BIT_BSY] = s_bsy;
        status_nxt[`SBC_BIT_REQ] = s_req;
        status_nxt[`SBC_BIT_ACK] = s_ack;
        status_nxt[`SBC_BIT_ATN] = s_atn;
        status_nxt[`SBC_BIT_RST] = s_rst;
        status_nxt[`SBC_BIT_LPAR] = s_lpar;
        status_nxt[`SBC_BIT_HPAR] = s_hpar;
        status_nxt[`SBC_BIT_LPERR] = lperr;
        status_nxt[`SBC_BIT_HPERR] = hperr;
        status_nxt[`SBC_BIT_WIDTH] = s_width;
    end

    // Matching word, errors and parity bits on top of reset and control lines.
    assign match_word = status_nxt[`SBC_MATCH_W-1:0];

    // Bus condition decode; reset has priority, then free, arbitration, selection.
    // Select alone with a handshake already active matches no condition and stays none.
    always_comb
    begin
        cond_nxt = SBC_COND_NONE;
        if (match_word[`SBC_BIT_RST])
            cond_nxt = SBC_COND_RESET;
        else if (!match_word[`SBC_BIT_BSY] && !match_word[`SBC_BIT_SEL])
            cond_nxt = SBC_COND_BUS_FREE;
        else if (match_word[`SBC_BIT_BSY] && match_word[`SBC_BIT_SEL])
            cond_nxt = match_word[`SBC_BIT_ATN] ? SBC_COND_ATTENTION_ARBITRATION
                                                : SBC_COND_ARBITRATION;
        else if (match_word[`SBC_BIT_SEL])
        begin
            if (!match_word[`SBC_BIT_REQ] && !match_word[`SBC_BIT_ACK])
                cond_nxt = match_word[`SBC_BIT_IO] ? SBC_COND_RESELECTION
                                                   : SBC_COND_SELECTION;
        end
        else
        begin
            case (match_word[2:0])
                `SBC_PH_DATA_OUT: cond_nxt = SBC_COND_DATA_OUT;
                `SBC_PH_DATA_IN: cond_nxt = SBC_COND_DATA_IN;
                `SBC_PH_COMMAND: cond_nxt = SBC_COND_COMMAND;
                `SBC_PH_STATUS: cond_nxt = SBC_COND_STATUS;
                `SBC_PH_MSG_OUT: cond_nxt = SBC_COND_MSG_OUT;
                `SBC_PH_MSG_IN: cond_nxt = SBC_COND_MSG_IN;
                default: cond_nxt = SBC_COND_UNDEFINED_PHASE;
            endcase
        end
    end

    // Parity error kind; only meaningful while bus reset is low.
    always_comb
    begin
        perr_nxt = SBC_PERR_NONE;
        if (!match_word[`SBC_BIT_RST])
        begin
            case ({match_word[`SBC_BIT_HPERR], match_word[`SBC_BIT_LPERR]})
                2'h1: perr_nxt = SBC_PERR_LOW;
                2'h2: perr_nxt = SBC_PERR_HIGH;
                2'h3: perr_nxt = SBC_PERR_BOTH;
                default: perr_nxt = SBC_PERR_NONE;
            endcase
        end
    end

    // Status, condition and parity load only on a sample event; sample_valid loads every cycle.
    // Between events they hold, so a reader always sees the last bus step.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            status_word <= `SBC_STATUS_RST;
            condition <= SBC_COND_NONE;
            parity_report <= SBC_PERR_NONE;
            sample_valid <= 1'b0;
        end
        else
        begin
            sample_valid <= sample_evt;
            if (sample_evt)
            begin
                status_word <= status_nxt;
                condition <= cond_nxt;
                parity_report <= perr_nxt;
            end
        end
    end

    assign bus_width_indicator = status_word[`SBC_BIT_WIDTH];
endmodule

// >>> sbc_checker.sv
module sbc_checker (
    input logic clk_sys,
    input logic rstn,
    input logic io_pin,
    input logic cd_pin,
    input logic msg_pin,
    input logic sel_pin,
    input logic bsy_pin,
    input logic req_pin,
    input logic ack_pin,
    input logic atn_pin,
    input logic rst_pin,
    input logic [15:0] data_pin,
    input logic low_byte_parity_bit_pin,
    input logic high_byte_parity_bit_pin,
    input logic bus_width_switch,
    input logic [15:0] status_word,
    input logic bus_width_indicator,
    input sbc_pkg::sbc_cond_t condition,
    input sbc_pkg::sbc_perr_t parity_report,
    input logic sample_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_pkg::*;
    // Pins need four edges to reach the status word, so checks look back four clock cycles.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    dir_bits_a: assert property (
        sample_valid |-> status_word[2:0] == $past({msg_pin, cd_pin, io_pin}, 4)) else $error("dir");
    ctl_bits_a: assert property (
        sample_valid |-> status_word[7:3] == $past({atn_pin, ack_pin, req_pin, bsy_pin, sel_pin}, 4))
        else $error("ctl");
    par_bits_a: assert property (
        sample_valid |-> status_word[10:8] ==
        $past({high_byte_parity_bit_pin, low_byte_parity_bit_pin, rst_pin}, 4)) else $error("par");
    perr_bits_a: assert property (
        sample_valid |-> status_word[12:11] == ~$past({^data_pin[15:8] ^ high_byte_parity_bit_pin,
        ^data_pin[7:0] ^ low_byte_parity_bit_pin}, 4)) else $error("perr");
    width_bit_a: assert property (
        sample_valid |-> status_word[15:13] == {$past(bus_width_switch, 4), 2'b00}
        && bus_width_indicator == status_word[15]) else $error("width");
    reset_cond_a: assert property (
        sample_valid && status_word[8] |-> condition == SBC_COND_RESET
        && parity_report == SBC_PERR_NONE) else $error("reset");
    free_cond_a: assert property (
        sample_valid && status_word[8] == 1'b0 && status_word[4:3] == 2'b00
        |-> condition == SBC_COND_BUS_FREE) else $error("free");
    arb_cond_a: assert property (
        sample_valid && status_word[8] == 1'b0 && status_word[4:3] == 2'b11
        |-> condition == (status_word[7] ? SBC_COND_ATTENTION_ARBITRATION : SBC_COND_ARBITRATION))
        else $error("arb");
    sel_cond_a: assert property (
        sample_valid && status_word[8] == 1'b0 && status_word[6:3] == 4'b0001
        |-> condition == (status_word[0] ? SBC_COND_RESELECTION : SBC_COND_SELECTION))
        else $error("sel");
    phase_cond_a: assert property (
        sample_valid && status_word[8] == 1'b0 && status_word[4:3] == 2'b10 |-> condition ==
        (status_word[2:1] == 2'b00 ? (status_word[0] ? SBC_COND_DATA_IN : SBC_COND_DATA_OUT) :
        status_word[2:1] == 2'b01 ? (status_word[0] ? SBC_COND_STATUS : SBC_COND_COMMAND) :
        status_word[2:1] == 2'b11 ? (status_word[0] ? SBC_COND_MSG_IN : SBC_COND_MSG_OUT) :
        SBC_COND_UNDEFINED_PHASE)) else $error("phase");
    perr_kind_a: assert property (
        sample_valid && status_word[8] == 1'b0 |-> parity_report ==
        (status_word[12:11] == 2'b00 ? SBC_PERR_NONE : status_word[12:11] == 2'b01 ? SBC_PERR_LOW :
        status_word[12:11] == 2'b10 ? SBC_PERR_HIGH : SBC_PERR_BOTH)) else $error("perr kind");
    // Main scenarios that the bench should reach.
    cover property (sample_valid && condition == SBC_COND_RESELECTION);
    cover property (sample_valid && condition == SBC_COND_MSG_IN);
    cover property (sample_valid && parity_report == SBC_PERR_BOTH);
    cover property (sample_valid && condition == SBC_COND_NONE);
endmodule

// >>> sbc_bus_model.sv
module sbc_bus_model (
    input logic clk_sys,
    output logic [8:0] ctl,
    output logic [15:0] data,
    output logic lpar,
    output logic hpar,
    output logic width
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus with correct odd parity over an all-zero data word.
    initial {ctl, data, lpar, hpar, width} = 28'h0000006;
    // One call plays target and initiator together, so req, ack and atn move as one state.
    // Parity stays odd unless a flip is asked for, the only fault this model makes.
    task automatic put(input logic [8:0] c, input logic [15:0] d, input logic [1:0] f);
        @(negedge clk_sys);
        ctl <= c;
        data <= d;
        lpar <= ~^d[7:0] ^ f[0];
        hpar <= ~^d[15:8] ^ f[1];
    endtask
    // The bus width switch moves on a falling edge like every other line.
    task automatic set_width(input logic w);
        @(negedge clk_sys);
        width <= w;
    endtask
endmodule

// >>> testbench.sv
`include "sbc_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_pkg::*;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [8:0] ctl;
    logic [15:0] data;
    logic [15:0] status_word;
    logic lpar, hpar, width, bus_width_indicator, sample_valid;
    sbc_cond_t condition;
    sbc_perr_t parity_report;
    int bad_count = 0;
    int checks_done = 0;
    sbc_bus_model bus (.clk_sys, .ctl, .data, .lpar, .hpar, .width);
    sbc_classifier DUT (.clk_sys, .rstn, .io_pin(ctl[0]), .cd_pin(ctl[1]), .msg_pin(ctl[2]),
        .sel_pin(ctl[3]), .bsy_pin(ctl[4]), .req_pin(ctl[5]), .ack_pin(ctl[6]), .atn_pin(ctl[7]),
        .rst_pin(ctl[8]), .data_pin(data), .low_byte_parity_bit_pin(lpar),
        .high_byte_parity_bit_pin(hpar), .bus_width_switch(width), .status_word,
        .bus_width_indicator, .condition, .parity_report, .sample_valid);
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end
    // Drive one bus state and judge the pulse it causes; data is varied with the state.
    task automatic step(input logic [8:0] c, input logic [1:0] f, input sbc_cond_t ec);
        logic [15:0] d;
        d = {c[7:0] ^ 8'h5A, c[8:1]};
        bus.put(c, d, f);
        repeat (8)
            if (sample_valid !== 1'b1)
                @(negedge clk_sys);
        `CHK("pulse", 1'b1, sample_valid)
        `CHK("status", {width, 2'b00, f, ~^d[15:8] ^ f[1], ~^d[7:0] ^ f[0], c}, status_word)
        `CHK("width", width, bus_width_indicator)
        `CHK("cond", ec, condition)
        `CHK("parity", c[8] ? SBC_PERR_NONE : sbc_perr_t'(4'h1 << f), parity_report)
    endtask
    // All eight phase codes with busy held; req toggles so that each state is sampled.
    task automatic t_phases();
        sbc_cond_t ph [8] = '{SBC_COND_DATA_OUT, SBC_COND_DATA_IN, SBC_COND_COMMAND,
            SBC_COND_STATUS, SBC_COND_UNDEFINED_PHASE, SBC_COND_UNDEFINED_PHASE,
            SBC_COND_MSG_OUT, SBC_COND_MSG_IN};
        for (int i = 0; i < 8; i++)
        begin
            step({3'b000, 3'b110, 3'(i)}, 2'b00, ph[i]);
            step({3'b000, 3'b010, 3'(i)}, 2'b00, ph[i]);
        end
    endtask
    // Free, both arbitration kinds, selection and reselection, with the wide setting.
    task automatic t_arbitration();
        bus.set_width(1'b1);
        step(9'h000, 2'b00, SBC_COND_BUS_FREE);
        step(9'h018, 2'b00, SBC_COND_ARBITRATION);
        step(9'h098, 2'b00, SBC_COND_ATTENTION_ARBITRATION);
        step(9'h008, 2'b00, SBC_COND_SELECTION);
        step(9'h000, 2'b00, SBC_COND_BUS_FREE);
        step(9'h009, 2'b00, SBC_COND_RESELECTION);
        step(9'h029, 2'b00, SBC_COND_NONE);
    endtask
    // Parity faults in each byte during a command phase, then a bus reset hides them.
    task automatic t_parity_reset();
        step(9'h012, 2'b01, SBC_COND_COMMAND);
        step(9'h032, 2'b10, SBC_COND_COMMAND);
        step(9'h012, 2'b11, SBC_COND_COMMAND);
        step(9'h112, 2'b11, SBC_COND_RESET);
    endtask
    // A reset in mid-run clears every output; the held bus reset is recorded again after it.
    task automatic t_midrun_reset();
        @(negedge clk_sys);
        rstn = 1'b0;
        @(negedge clk_sys);
        `CHK("rst status", `SBC_STATUS_RST, status_word)
        `CHK("rst cond", SBC_COND_NONE, condition)
        `CHK("rst parity", SBC_PERR_NONE, parity_report)
        `CHK("rst pulse", 1'b0, sample_valid)
        rstn = 1'b1;
        step(9'h112, 2'b11, SBC_COND_RESET);
    endtask
    task automatic conclude();
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence, released on a falling edge after two cycles of reset.
    initial
    begin
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        `CHK("idle", SBC_COND_NONE, condition)
        t_phases();
        t_arbitration();
        t_parity_reset();
        t_midrun_reset();
        conclude();
    end
    // About 30 samples of under ten cycles each; a clean run ends well before this.
    initial
    begin
        repeat (1000) @(posedge clk_sys);
        bad_count++;
        conclude();
    end
endmodule
bind sbc_classifier sbc_checker chk (.clk_sys, .rstn, .io_pin, .cd_pin, .msg_pin, .sel_pin,
    .bsy_pin, .req_pin, .ack_pin, .atn_pin, .rst_pin, .data_pin, .low_byte_parity_bit_pin,
    .high_byte_parity_bit_pin, .bus_width_switch, .status_word, .bus_width_indicator,
    .condition, .parity_report, .sample_valid);
